// ---- inc/dcf_pkg.sv ----
package dcf_pkg;
  // ************************************************
  // widths and sizes
  // ************************************************
  localparam int DCF_DW = 8;
  localparam int DCF_FIFO_DEPTH = 16;
  localparam int DCF_MAX_WBYTES = 8;
  localparam int DCF_ADDR_W = 6;
  localparam int DCF_NFLAGS = 6;
  // ************************************************
  // frame fields
  // ************************************************
  localparam int DCF_TYPE_BIT = 7;
  localparam int DCF_REQ_HI = 6;
  localparam int DCF_REQ_LO = 4;
  localparam int DCF_SIZE_HI = 2;
  localparam int DCF_SIZE_LO = 0;
  localparam int DCF_RCNT_HI = 6;
  localparam logic [15:0] DCF_CRC_INIT = 16'hffff;
  // x^16+x^15+x^2+1 bit-reversed, since bytes go lsb first
  localparam logic [15:0] DCF_CRC_POLY_REFL = 16'ha001;
  localparam logic [2:0] DCF_REQ_SRD = 3'h0;
  localparam logic [2:0] DCF_REQ_SWR = 3'h1;
  localparam logic [2:0] DCF_REQ_KRD = 3'h2;
  localparam logic [2:0] DCF_REQ_KWR = 3'h3;
  localparam logic [2:0] DCF_REQ_BRD = 3'h4;
  localparam logic [2:0] DCF_REQ_BWR = 3'h5;
  localparam logic [2:0] DCF_REQ_RWR = 3'h6;
  localparam logic [2:0] DCF_REQ_RSVD = 3'h7;
  // ************************************************
  // status flag positions
  // ************************************************
  localparam int DCF_F_CLR = 0;
  localparam int DCF_F_STOP = 1;
  localparam int DCF_F_CRC = 2;
  localparam int DCF_F_IERR = 3;
  localparam int DCF_F_WAIT = 4;
  localparam int DCF_F_SOF = 5;
  localparam logic [DCF_NFLAGS-1:0] DCF_FLAGS_RST = 6'h00;

  typedef enum logic [11:0] {
    DCF_ST_INIT = 12'h001,
    DCF_ST_DEVADR = 12'h002,
    DCF_ST_REGH = 12'h004,
    DCF_ST_REGL = 12'h008,
    DCF_ST_DATA = 12'h010,
    DCF_ST_CRCL = 12'h020,
    DCF_ST_CRCH = 12'h040,
    DCF_ST_EVAL = 12'h080,
    DCF_ST_WR = 12'h100,
    DCF_ST_HDR = 12'h200,
    DCF_ST_RD = 12'h400,
    DCF_ST_CRC = 12'h800
  } dcf_state_t;

  function automatic logic [15:0] dcf_crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ DCF_CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ---- rtl/dcf_fifo.sv ----
`timescale 1ns/100ps
module dcf_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic ref_clk_i, // clock
  input wire logic rstn_i, // async reset, low
  input wire logic flush_i, // drop all content
  input wire logic in_valid_i, // write request
  output logic in_ready_o, // room left
  input wire logic [W-1:0] in_data_i, // write word
  output logic out_valid_o, // word available
  input wire logic out_ready_i, // read accept
  output logic [W-1:0] out_data_o // head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic full, empty, wr, rd;

  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty = (wp_q == rp_q);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_q[rp_q[AW-1:0]];
  assign wr = in_valid_i && !full;
  assign rd = out_ready_i && !empty;

  always_comb begin
    wp_d = wr ? wp_q + 1'b1 : wp_q;
    rp_d = rd ? rp_q + 1'b1 : rp_q;
    if (flush_i) begin
      wp_d = '0;
      rp_d = '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // storage needs no reset; pointers guard it
  always_ff @(posedge ref_clk_i) begin
    if (wr) begin
      mem_q[wp_q[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// ---- rtl/dcf_frame.sv ----
`timescale 1ns/100ps
// What this block does
// RULE1 - link-clear pulse acts on this receive port only, any time, even while sending
// RULE2 - link-clear resets the frame receiver; next byte is start of frame
// RULE3 - link-clear sets clear-detected and missing-stop flags
// RULE4 - host keeps clear pulse short and waits recovery time before next frame
// RULE5 - wake tone resets receiver; sets clear flag, plus stop flag when already awake
// RULE6 - link-clear during pending or outgoing response discards own response
// RULE7 - such discard sets pending-response or clear-during-transmit debug bit
// RULE8 - host precedes multidrop frames with clear, waits for stack responses first
// RULE9 - device sends only response frames to received read commands
// RULE10 - host waits for all responses or timeout before next command
// RULE11 - stack read and write act only when stack member bit is 1
// RULE12 - broadcast read and write act on every device including base
// RULE13 - reverse broadcast write goes opposite to current direction select
// RULE14 - frame order: init, optional address, two register bytes, data, two check
// RULE15 - init bit 7: 1 command frame, 0 response frame
// RULE16 - init bits 6..4 pick request; 111 only sets init error; bit 3 ignored
// RULE17 - command init bits 2..0 hold data byte count minus one
// RULE18 - response init low seven bits hold returned count minus one
// RULE19 - address byte only in single commands and all responses
// RULE20 - address byte holds six-bit address in bits 5..0, upper bits zero
// RULE21 - single commands match forward address if direction 0, else reverse address
// RULE22 - invalid register writes ignored, reads return 0x00, valid ones normal
// RULE23 - check field is crc-16 x^16+x^15+x^2+1, init all ones, whole frame
// RULE24 - check verified first; mismatch drops frame, flags only check error
// RULE25 - bytes go lsb first and check follows that bit order
// RULE26 - read command data byte is return count minus one, up to 128
// RULE27 - init byte type and size give the exact count of bytes to expect
module dcf_frame
  import dcf_pkg::*;
#(
  parameter int FIFO_DEPTH = dcf_pkg::DCF_FIFO_DEPTH
) (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic rstn_i, // async reset, low
  input wire logic [dcf_pkg::DCF_DW-1:0] rx_data_i, // received byte
  input wire logic rx_valid_i, // received byte strobe
  input wire logic rx_stop_err_i, // byte had low stop bit
  input wire logic clear_pulse_i, // link_clear_pulse seen
  input wire logic wake_tone_i, // wake_tone seen
  input wire logic asleep_i, // device in sleep mode
  input wire logic stack_member_i, // stack_member_bit
  input wire logic dir_sel_i, // direction select
  input wire logic [dcf_pkg::DCF_ADDR_W-1:0] fwd_addr_i, // forward_node_address
  input wire logic [dcf_pkg::DCF_ADDR_W-1:0] rev_addr_i, // reverse_node_address
  input wire logic [dcf_pkg::DCF_DW-1:0] reg_rdata_i, // register read data
  input wire logic reg_hit_i, // reg_addr_o is a valid register
  input wire logic tx_ready_i, // transmitter takes byte
  input wire logic [dcf_pkg::DCF_NFLAGS-1:0] flag_clr_i, // clear flags, one-cycle
  output logic [15:0] reg_addr_o, // register address
  output logic [dcf_pkg::DCF_DW-1:0] reg_wdata_o, // register write data
  output logic reg_we_o, // register write pulse
  output logic reg_re_o, // register read pulse
  output logic [dcf_pkg::DCF_DW-1:0] tx_data_o, // response byte
  output logic tx_valid_o, // response byte valid
  output logic cmd_done_o, // command accepted pulse
  output logic cmd_dir_o, // forwarding direction
  output logic [dcf_pkg::DCF_NFLAGS-1:0] flags_o // sticky status flags
);
  // ************************************************
  // state
  // ************************************************
  dcf_state_t st_q, st_d;
  logic [7:0] init_q, init_d, dadr_q, dadr_d, cnt_q, cnt_d;
  logic [15:0] radr_q, radr_d, crc_q, crc_d, addr_q, addr_d;
  logic [7:0] data_q [DCF_MAX_WBYTES];
  logic [7:0] data_d [DCF_MAX_WBYTES];
  logic [7:0] wdata_q, wdata_d, odata_q, odata_d;
  logic ph_q, ph_d, we_q, we_d, re_q, re_d, done_q, done_d, dir_q, dir_d;
  logic ovalid_q, ovalid_d, sent_q, sent_d;
  logic [DCF_NFLAGS-1:0] flags_q, flags_d, set;
  logic push_v, fifo_rdy, fifo_ov, fifo_rd, flush;
  logic [7:0] push_b, fifo_od, dlen;
  logic [2:0] req;
  logic [5:0] my_addr;
  logic act, in_resp, rst_ev, ev_ok;

  function automatic logic is_single(input logic [2:0] r);
    return (r == DCF_REQ_SRD) || (r == DCF_REQ_SWR);
  endfunction

  assign req = init_q[DCF_REQ_HI:DCF_REQ_LO];
  assign my_addr = dir_sel_i ? rev_addr_i : fwd_addr_i; // RULE21
  // responses carry 7-bit count, commands 3-bit
  assign dlen = init_q[DCF_TYPE_BIT] ? {5'h00, init_q[DCF_SIZE_HI:DCF_SIZE_LO]} : {1'b0, init_q[6:0]}; // RULE17 RULE27
  assign in_resp = (st_q == DCF_ST_HDR) || (st_q == DCF_ST_RD) || (st_q == DCF_ST_CRC);
  assign rst_ev = clear_pulse_i || wake_tone_i;
  assign ev_ok = (st_q == DCF_ST_EVAL) && !rst_ev;
  assign fifo_rd = !ovalid_q || tx_ready_i;

  // ************************************************
  // acceptance of a checked command
  // ************************************************
  always_comb begin
    case (req)
      DCF_REQ_SRD, DCF_REQ_SWR: act = (dadr_q[5:0] == my_addr); // RULE20 RULE21
      DCF_REQ_KRD, DCF_REQ_KWR: act = stack_member_i; // RULE11
      DCF_REQ_BRD, DCF_REQ_BWR, DCF_REQ_RWR: act = 1'b1; // RULE12
      default: act = 1'b0;
    endcase
  end

  // ************************************************
  // frame receive, execute and respond
  // ************************************************
  always_comb begin
    st_d = st_q;
    init_d = init_q;
    dadr_d = dadr_q;
    radr_d = radr_q;
    cnt_d = cnt_q;
    crc_d = crc_q;
    data_d = data_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    ph_d = ph_q;
    dir_d = dir_q;
    sent_d = sent_q;
    we_d = 1'b0;
    re_d = 1'b0;
    done_d = 1'b0;
    set = '0;
    push_v = 1'b0;
    push_b = 8'h00;
    flush = 1'b0;
    case (st_q)
      DCF_ST_INIT: begin
        if (rx_valid_i) begin
          init_d = rx_data_i;
          crc_d = dcf_crc_byte(DCF_CRC_INIT, rx_data_i); // RULE23 RULE25
          cnt_d = 8'h00;
          // responses and single commands carry an address byte
          if (!rx_data_i[DCF_TYPE_BIT] || is_single(rx_data_i[DCF_REQ_HI:DCF_REQ_LO])) begin // RULE15 RULE19
            st_d = DCF_ST_DEVADR;
          end else begin
            st_d = DCF_ST_REGH;
          end
        end
      end
      DCF_ST_DEVADR, DCF_ST_REGH, DCF_ST_REGL, DCF_ST_DATA, DCF_ST_CRCL, DCF_ST_CRCH: begin
        if (rx_valid_i) begin
          crc_d = dcf_crc_byte(crc_q, rx_data_i); // RULE14
          case (st_q)
            DCF_ST_DEVADR: begin
              dadr_d = rx_data_i;
              st_d = DCF_ST_REGH;
            end
            DCF_ST_REGH: begin
              radr_d[15:8] = rx_data_i;
              st_d = DCF_ST_REGL;
            end
            DCF_ST_REGL: begin
              radr_d[7:0] = rx_data_i;
              st_d = DCF_ST_DATA;
            end
            DCF_ST_DATA: begin
              // long response frames are counted, only the first bytes kept
              if (cnt_q < DCF_MAX_WBYTES) begin
                data_d[cnt_q[2:0]] = rx_data_i;
              end
              cnt_d = cnt_q + 8'h01;
              if (cnt_q == dlen) begin // RULE27
                st_d = DCF_ST_CRCL;
              end
            end
            DCF_ST_CRCL: st_d = DCF_ST_CRCH;
            default: st_d = DCF_ST_EVAL;
          endcase
        end
      end
      DCF_ST_EVAL: begin
        st_d = DCF_ST_INIT;
        cnt_d = 8'h00;
        ph_d = 1'b0;
        if (crc_q != 16'h0000) begin
          set[DCF_F_CRC] = 1'b1; // RULE24
        end else if (init_q[DCF_TYPE_BIT]) begin
          if (req == DCF_REQ_RSVD) begin
            set[DCF_F_IERR] = 1'b1; // RULE16
          end else if (act) begin
            done_d = 1'b1;
            dir_d = dir_sel_i ^ (req == DCF_REQ_RWR); // RULE13
            sent_d = 1'b0;
            if (req[0] || req == DCF_REQ_RWR) begin
              st_d = DCF_ST_WR;
            end else begin
              st_d = DCF_ST_HDR; // RULE9
              crc_d = DCF_CRC_INIT;
            end
          end
        end
      end
      DCF_ST_WR: begin
        if (!ph_q) begin
          addr_d = radr_q + {8'h00, cnt_q};
          wdata_d = data_q[cnt_q[2:0]];
          ph_d = 1'b1;
        end else begin
          we_d = reg_hit_i; // RULE22
          ph_d = 1'b0;
          cnt_d = cnt_q + 8'h01;
          if (cnt_q == dlen) begin
            st_d = DCF_ST_INIT;
          end
        end
      end
      DCF_ST_HDR, DCF_ST_CRC: begin
        push_v = 1'b1;
        case (cnt_q[2:0])
          3'h0: push_b = {1'b0, data_q[0][DCF_RCNT_HI:0]}; // RULE18 RULE26
          3'h1: push_b = {2'b00, my_addr}; // RULE19 RULE20
          3'h2: push_b = radr_q[15:8];
          default: push_b = radr_q[7:0];
        endcase
        if (st_q == DCF_ST_CRC) begin
          push_b = cnt_q[0] ? crc_q[15:8] : crc_q[7:0];
        end
        if (fifo_rdy) begin
          cnt_d = cnt_q + 8'h01;
          if (st_q == DCF_ST_HDR) begin
            crc_d = dcf_crc_byte(crc_q, push_b);
            if (cnt_q == 8'h03) begin
              st_d = DCF_ST_RD;
              cnt_d = 8'h00;
            end
          end else if (cnt_q[0]) begin
            st_d = DCF_ST_INIT;
          end
        end
      end
      DCF_ST_RD: begin
        if (!ph_q) begin
          addr_d = radr_q + {8'h00, cnt_q};
          re_d = 1'b1;
          ph_d = 1'b1;
        end else begin
          push_v = 1'b1;
          push_b = reg_hit_i ? reg_rdata_i : 8'h00; // RULE22
          if (fifo_rdy) begin
            crc_d = dcf_crc_byte(crc_q, push_b);
            ph_d = 1'b0;
            cnt_d = cnt_q + 8'h01;
            if (cnt_q == {1'b0, data_q[0][DCF_RCNT_HI:0]}) begin
              st_d = DCF_ST_CRC;
              cnt_d = 8'h00;
            end
          end
        end
      end
      default: st_d = DCF_ST_INIT;
    endcase
    if (ovalid_q && tx_ready_i) begin
      sent_d = 1'b1;
    end
    if (rx_stop_err_i) begin
      set[DCF_F_STOP] = 1'b1;
    end
    // receive path never muted, so a clear cuts through a response
    if (rst_ev) begin // RULE1
      st_d = DCF_ST_INIT; // RULE2 RULE5
      we_d = 1'b0;
      re_d = 1'b0;
      done_d = 1'b0;
      push_v = 1'b0;
      set[DCF_F_CLR] = 1'b1; // RULE3 RULE5
      if (clear_pulse_i || !asleep_i) begin
        set[DCF_F_STOP] = 1'b1; // RULE3 RULE5
      end
      if (in_resp || fifo_ov || ovalid_q) begin
        flush = 1'b1; // RULE6
        set[sent_q ? DCF_F_SOF : DCF_F_WAIT] = 1'b1; // RULE7
      end
    end
  end

  // ************************************************
  // output stage and flags
  // ************************************************
  always_comb begin
    ovalid_d = ovalid_q;
    odata_d = odata_q;
    if (fifo_rd) begin
      ovalid_d = fifo_ov;
      odata_d = fifo_od;
    end
    if (flush) begin
      ovalid_d = 1'b0;
    end
  end

  // set beats a clear in the same cycle
  for (genvar i = 0; i < DCF_NFLAGS; i++) begin : g_flag
    assign flags_d[i] = set[i] | (flags_q[i] & ~flag_clr_i[i]);
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= DCF_ST_INIT;
      init_q <= 8'h00;
      dadr_q <= 8'h00;
      radr_q <= 16'h0000;
      cnt_q <= 8'h00;
      crc_q <= DCF_CRC_INIT;
      data_q <= '{default: 8'h00};
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      odata_q <= 8'h00;
      {ph_q, we_q, re_q, done_q, dir_q, ovalid_q, sent_q} <= 7'h00;
      flags_q <= DCF_FLAGS_RST;
    end else begin
      st_q <= st_d;
      init_q <= init_d;
      dadr_q <= dadr_d;
      radr_q <= radr_d;
      cnt_q <= cnt_d;
      crc_q <= crc_d;
      data_q <= data_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      odata_q <= odata_d;
      {ph_q, we_q, re_q, done_q, dir_q, ovalid_q, sent_q} <= {ph_d, we_d, re_d, done_d, dir_d, ovalid_d, sent_d};
      flags_q <= flags_d;
    end
  end

  dcf_fifo #(.W(DCF_DW), .D(FIFO_DEPTH)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .flush_i(flush),
    .in_valid_i(push_v),
    .in_ready_o(fifo_rdy),
    .in_data_i(push_b),
    .out_valid_o(fifo_ov),
    .out_ready_i(fifo_rd),
    .out_data_o(fifo_od)
  );

  assign reg_addr_o = addr_q;
  assign reg_wdata_o = wdata_q;
  assign reg_we_o = we_q;
  assign reg_re_o = re_q;
  assign tx_data_o = odata_q;
  assign tx_valid_o = ovalid_q;
  assign cmd_done_o = done_q;
  assign cmd_dir_o = dir_q;
  assign flags_o = flags_q;

  // ************************************************
  // checks
  // ************************************************
  a_clear_restarts: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE2
    clear_pulse_i |=> st_q == DCF_ST_INIT) else $error("clear did not restart receiver");
  a_clear_flags_set: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE3
    clear_pulse_i |=> flags_q[DCF_F_CLR] && flags_q[DCF_F_STOP]) else $error("clear flags missing");
  a_wake_active_flags: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE5
    wake_tone_i && !asleep_i && !rx_stop_err_i && !clear_pulse_i && !flags_q[DCF_F_STOP]
    |=> flags_q[DCF_F_CLR] && flags_q[DCF_F_STOP]) else $error("wake flags wrong");
  a_resp_only_reads: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE9
    push_v && fifo_rdy |-> in_resp) else $error("unsolicited transmit");
  a_clear_discards: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE6
    clear_pulse_i && in_resp |=> !tx_valid_o ##1 !tx_valid_o) else $error("response not discarded");
  a_discard_debug: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE7
    clear_pulse_i && in_resp |=> flags_q[DCF_F_WAIT] || flags_q[DCF_F_SOF]) else $error("no debug bit");
  a_stack_gated: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE11
    ev_ok && crc_q == 16'h0000 && init_q[7] && (req == DCF_REQ_KRD || req == DCF_REQ_KWR) && !stack_member_i
    |=> !cmd_done_o && st_q == DCF_ST_INIT) else $error("stack command without membership");
  a_crc_drop: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE24
    ev_ok && crc_q != 16'h0000 |=> flags_q[DCF_F_CRC] && !cmd_done_o && !reg_we_o) else $error("bad frame run");
  a_init_error: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE16
    ev_ok && crc_q == 16'h0000 && init_q[7] && req == DCF_REQ_RSVD |=> flags_q[DCF_F_IERR] && !cmd_done_o)
    else $error("reserved request not flagged");
  a_reverse_dir: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE13
    ev_ok && crc_q == 16'h0000 && init_q[7] && req == DCF_REQ_RWR |=> cmd_dir_o != $past(dir_sel_i))
    else $error("reverse write kept direction");
  a_invalid_write: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE22
    st_q == DCF_ST_WR && ph_q && !reg_hit_i && !rst_ev |=> !reg_we_o) else $error("write to invalid register");
endmodule

// ---- bench/dcf_host_model.sv ----
`timescale 1ns/100ps
module dcf_host_model
  import dcf_pkg::*;
(
  input wire logic ref_clk_i, // clock
  input wire logic rstn_i, // async reset, low
  input wire logic stall_i, // hold off the response stream
  input wire logic [15:0] reg_addr_i, // register address
  input wire logic [dcf_pkg::DCF_DW-1:0] reg_wdata_i, // write data
  input wire logic reg_we_i, // write pulse
  input wire logic [dcf_pkg::DCF_DW-1:0] tx_data_i, // response byte
  input wire logic tx_valid_i, // response byte valid
  output logic tx_ready_o, // byte taken
  output logic reg_hit_o, // address is a register
  output logic [dcf_pkg::DCF_DW-1:0] reg_rdata_o // read data
);
  // ****************************
  // register file and byte sink
  // ****************************
  logic [7:0] regs [16];
  logic [7:0] got [$];
  int n_bad_we;
  assign tx_ready_o = !stall_i;
  assign reg_hit_o = (reg_addr_i[15:4] == 12'h001);
  // junk on a miss, so a missing zero fill shows
  assign reg_rdata_o = reg_hit_o ? regs[reg_addr_i[3:0]] : 8'h5a;
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 16; i++) begin
        regs[i] <= 8'h40 + 8'(i);
      end
      n_bad_we <= 0;
    end else begin
      if (reg_we_i && reg_hit_o) regs[reg_addr_i[3:0]] <= reg_wdata_i;
      if (reg_we_i && !reg_hit_o) n_bad_we <= n_bad_we + 1;
      if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
    end
  end
endmodule

// ---- bench/dcf_frame_test.sv ----
`timescale 1ns/100ps
module dcf_frame_test;
  import dcf_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00;
  logic rx_valid_i = 1'b0, rx_stop_err_i = 1'b0, clear_pulse_i = 1'b0, wake_tone_i = 1'b0;
  logic asleep_i = 1'b0, stack_member_i = 1'b0, dir_sel_i = 1'b0, stall = 1'b0;
  logic [5:0] fwd_addr_i = 6'h05, rev_addr_i = 6'h2a, tgt = 6'h05, flag_clr_i = 6'h00;
  logic [15:0] reg_addr_o, c;
  logic [7:0] reg_wdata_o, reg_rdata_i, tx_data_o;
  logic reg_we_o, reg_re_o, reg_hit_i, tx_valid_o, tx_ready_i, cmd_done_o, cmd_dir_o;
  logic [5:0] flags_o;
  logic [7:0] fq [$];
  logic [7:0] eq [$];
  logic [2:0] wr [4] = '{DCF_REQ_SWR, DCF_REQ_KWR, DCF_REQ_BWR, DCF_REQ_RWR};
  int n_mismatch = 0, n_compared = 0;
  int n_re = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  // register read strobes, one per register fetched for a response
  always @(posedge ref_clk_i) if (reg_re_o === 1'b1) n_re <= n_re + 1;
  dcf_frame dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
    .rx_stop_err_i(rx_stop_err_i), .clear_pulse_i(clear_pulse_i), .wake_tone_i(wake_tone_i),
    .asleep_i(asleep_i), .stack_member_i(stack_member_i), .dir_sel_i(dir_sel_i), .fwd_addr_i(fwd_addr_i),
    .rev_addr_i(rev_addr_i), .reg_rdata_i(reg_rdata_i), .reg_hit_i(reg_hit_i), .tx_ready_i(tx_ready_i),
    .flag_clr_i(flag_clr_i), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .reg_we_o(reg_we_o),
    .reg_re_o(reg_re_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .cmd_done_o(cmd_done_o),
    .cmd_dir_o(cmd_dir_o), .flags_o(flags_o));
  dcf_host_model host (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .stall_i(stall), .reg_addr_i(reg_addr_o),
    .reg_wdata_i(reg_wdata_o), .reg_we_i(reg_we_o), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
    .tx_ready_o(tx_ready_i), .reg_hit_o(reg_hit_i), .reg_rdata_o(reg_rdata_i));
  // ****************************
  // access tasks
  // ****************************
  function automatic logic [15:0] crc_step(input logic [15:0] cc, input logic [7:0] b);
    logic [15:0] r;
    r = cc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) r = r[0] ? (r >> 1) ^ 16'ha001 : r >> 1;
    return r;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // bad flips one check bit so the frame must be dropped
  task automatic cmd(input logic [2:0] req, input logic [15:0] ra, input int n, input logic [7:0] d0,
    input logic bad);
    logic [15:0] cc;
    fq.delete();
    fq.push_back({1'b1, req, 1'b0, 3'(n - 1)});
    if (req == DCF_REQ_SRD || req == DCF_REQ_SWR) fq.push_back({2'b00, tgt});
    fq.push_back(ra[15:8]);
    fq.push_back(ra[7:0]);
    for (int i = 0; i < n; i++) fq.push_back(d0 + 8'(i));
    cc = 16'hffff;
    foreach (fq[i]) cc = crc_step(cc, fq[i]);
    fq.push_back(cc[7:0] ^ {7'h00, bad});
    fq.push_back(cc[15:8]);
    foreach (fq[i]) begin
      @(posedge ref_clk_i);
      rx_data_i <= fq[i];
      rx_valid_i <= 1'b1;
    end
    @(posedge ref_clk_i);
    rx_valid_i <= 1'b0;
  endtask
  task automatic done_in(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(posedge ref_clk_i);
      #1;
      if (cmd_done_o === 1'b1) seen = 1'b1;
    end
    check("cmd_done", seen, exp);
  endtask
  task automatic pulse(input logic [2:0] m, input logic [5:0] clr);
    @(posedge ref_clk_i);
    {wake_tone_i, clear_pulse_i, rx_stop_err_i} <= m;
    flag_clr_i <= clr;
    @(posedge ref_clk_i);
    {wake_tone_i, clear_pulse_i, rx_stop_err_i} <= 3'b000;
    flag_clr_i <= 6'h00;
    tick(3);
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ****************************
  // tests
  // ****************************
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    stall <= 1'b1;
    cmd(DCF_REQ_SRD, 16'h0010, 1, 8'h11, 1'b0);
    tick(60);
    check("stalled", 16'(host.got.size()), 16'h0);
    @(posedge ref_clk_i);
    stall <= 1'b0;
    tick(80);
    eq = '{8'h11, {2'b00, fwd_addr_i}, 8'h00, 8'h10};
    for (int i = 0; i < 18; i++) eq.push_back(i < 16 ? 8'h40 + 8'(i) : 8'h00);
    c = 16'hffff;
    foreach (eq[i]) c = crc_step(c, eq[i]);
    eq.push_back(c[7:0]);
    eq.push_back(c[15:8]);
    check("rsp_len", 16'(host.got.size()), 16'(eq.size()));
    foreach (eq[i]) check("rsp_byte", host.got[i], eq[i]);
    check("rd_pulses", 16'(n_re), 16'h0012);
    @(posedge ref_clk_i);
    stack_member_i <= 1'b1;
    foreach (wr[k]) begin
      cmd(wr[k], 16'h0010 + 16'(k), 1, 8'ha0 + 8'(k), 1'b0);
      done_in(1'b1);
      check("reg_wr", host.regs[k], 8'ha0 + 8'(k));
      check("cmd_dir", cmd_dir_o, wr[k] == DCF_REQ_RWR);
    end
    cmd(DCF_REQ_SWR, 16'h001c, 8, 8'hc0, 1'b0);
    done_in(1'b1);
    // eight writes at two cycles each outlast the done window
    tick(12);
    for (int i = 0; i < 4; i++) check("blk_wr", host.regs[12 + i], 8'hc0 + 8'(i));
    check("miss_wr", 16'(host.n_bad_we), 16'h0);
    @(posedge ref_clk_i);
    stack_member_i <= 1'b0;
    cmd(DCF_REQ_KWR, 16'h0010, 1, 8'h00, 1'b0);
    done_in(1'b0);
    host.got.delete();
    cmd(DCF_REQ_KRD, 16'h0010, 1, 8'h00, 1'b0);
    tick(40);
    cmd(DCF_REQ_BRD, 16'h0010, 1, 8'h00, 1'b0);
    tick(40);
    check("brd_len", 16'(host.got.size()), 16'h7);
    check("brd_init", host.got[0], 8'h00);
    tgt = 6'h06;
    cmd(DCF_REQ_SWR, 16'h0010, 1, 8'h77, 1'b0);
    done_in(1'b0);
    @(posedge ref_clk_i);
    dir_sel_i <= 1'b1;
    tgt = rev_addr_i;
    cmd(DCF_REQ_SWR, 16'h0011, 1, 8'h78, 1'b0);
    done_in(1'b1);
    check("dir1", cmd_dir_o, 1'b1);
    cmd(DCF_REQ_RWR, 16'h0011, 1, 8'h79, 1'b0);
    done_in(1'b1);
    check("dir_rev", cmd_dir_o, 1'b0);
    pulse(3'b000, 6'h3f);
    cmd(DCF_REQ_BWR, 16'h0012, 1, 8'h7a, 1'b1);
    done_in(1'b0);
    check("crc_flag", flags_o, 6'h04);
    check("crc_nowr", host.regs[2], 8'ha2);
    pulse(3'b000, 6'h3f);
    cmd(DCF_REQ_RSVD, 16'h0012, 1, 8'h7b, 1'b0);
    done_in(1'b0);
    check("ierr", flags_o, 6'h08);
    pulse(3'b001, 6'h3f);
    check("stop", flags_o, 6'h02);
    pulse(3'b010, 6'h3f);
    check("clr", flags_o, 6'h03);
    @(posedge ref_clk_i);
    asleep_i <= 1'b1;
    pulse(3'b100, 6'h3f);
    check("wake_sleep", flags_o, 6'h01);
    @(posedge ref_clk_i);
    asleep_i <= 1'b0;
    pulse(3'b100, 6'h3f);
    check("wake_act", flags_o, 6'h03);
    pulse(3'b000, 6'h3f);
    host.got.delete();
    stall <= 1'b1;
    cmd(DCF_REQ_SRD, 16'h0010, 1, 8'h03, 1'b0);
    tick(12);
    pulse(3'b010, 6'h00);
    check("drop_dbg", flags_o[DCF_F_WAIT] | flags_o[DCF_F_SOF], 1'b1);
    @(posedge ref_clk_i);
    stall <= 1'b0;
    tick(40);
    check("dropped", 16'(host.got.size()), 16'h0);
    tick(20);
    cmd(DCF_REQ_SWR, 16'h0013, 1, 8'h5c, 1'b0);
    done_in(1'b1);
    check("after_clr", host.regs[3], 8'h5c);
    end_of_test();
  end
endmodule
